/* File: pkg/bib_pkg.sv */
// Constants and types shared by the board information bank
package bib_pkg;

  // ==========================================================
  // Parameter numbers seen by the parameter read call
  // ==========================================================
  localparam int NUM_W = 16;
  localparam logic [NUM_W-1:0] NUM_BOARD_TYPE = 16'h07D0;
  localparam logic [NUM_W-1:0] NUM_HW_REV = 16'h07DA;
  localparam logic [NUM_W-1:0] NUM_EXP_REV = 16'h07DB;
  localparam logic [NUM_W-1:0] NUM_DATE = 16'h07E4;
  localparam logic [NUM_W-1:0] NUM_SERIAL = 16'h07EE;
  localparam logic [NUM_W-1:0] NUM_MAX_RATE = 16'h0834;
  localparam logic [NUM_W-1:0] NUM_MEM_BYTES = 16'h083E;
  localparam logic [NUM_W-1:0] NUM_OPTIONS = 16'h0848;
  localparam logic [NUM_W-1:0] NUM_IRQ_LINE = 16'h08FC;

  // ==========================================================
  // Word slots in the nonvolatile image and local store
  // ==========================================================
  localparam int NV_WORDS = 8;
  localparam int IDX_W = 3;
  localparam logic [IDX_W-1:0] IDX_BOARD_TYPE = 3'h0;
  localparam logic [IDX_W-1:0] IDX_HW_REV = 3'h1;
  localparam logic [IDX_W-1:0] IDX_EXP_REV = 3'h2;
  localparam logic [IDX_W-1:0] IDX_DATE = 3'h3;
  localparam logic [IDX_W-1:0] IDX_SERIAL = 3'h4;
  localparam logic [IDX_W-1:0] IDX_MAX_RATE = 3'h5;
  localparam logic [IDX_W-1:0] IDX_MEM_BYTES = 3'h6;
  localparam logic [IDX_W-1:0] IDX_OPTIONS = 3'h7;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;

  // ==========================================================
  // Field layouts
  // ==========================================================
  localparam logic [31:0] HW_REV_MASK = 32'h0000FFFF;
  localparam int HW_REV_BASE_LSB = 8;
  localparam logic [31:0] DATE_MASK = 32'hFFFF00FF;
  localparam logic [31:0] DATE_UNUSED = 32'h0000FF00;
  localparam int IRQ_W = 8;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  // ==========================================================
  // Installed option bits
  // ==========================================================
  localparam int OPT_MULTI_BIT = 0;
  localparam int OPT_DIGITAL_BIT = 1;
  localparam int OPT_GATE_BIT = 5;
  localparam int OPT_SYNC_BIT = 9;
  localparam int OPT_TIMESTAMP_BIT = 10;
  localparam int OPT_HUB_BIT = 11;
  localparam int OPT_XIO_BIT = 13;
  localparam int OPT_AMP_BIT = 14;
  localparam logic [31:0] OPT_DEFINED = 32'h00006E23;

  // ==========================================================
  // Sample storage
  // ==========================================================
  localparam int NARROW_SAMPLE_BITS = 8;
  localparam logic [1:0] BPS_NARROW = 2'h1;
  localparam logic [1:0] BPS_WIDE = 2'h2;

  // ==========================================================
  // Bank sequencing
  // ==========================================================
  typedef enum logic [2:0] {
    BIB_WAIT_INIT = 3'b001,
    BIB_LOADING = 3'b010,
    BIB_READY = 3'b100
  } bib_state_e;

endpackage

/* File: verilog/bib_nv_loader.sv */
// Sequencer copying the board information image out of nonvolatile memory
`timescale 1ns/100ps
module bib_nv_loader import bib_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic nv_ack_i,
  input wire logic [31:0] nv_data_i,
  output logic nv_req_o,
  output logic [IDX_W-1:0] nv_addr_o,
  output logic st_we_o,
  output logic [IDX_W-1:0] st_idx_o,
  output logic [31:0] st_data_o,
  output logic done_o
);

  logic busy_reg, busy_next;
  logic [IDX_W-1:0] idx_reg, idx_next;
  logic we_reg, we_next;
  logic [IDX_W-1:0] widx_reg, widx_next;
  logic [31:0] wdata_reg, wdata_next;
  logic done_reg, done_next;

  // ==========================================================
  // Walk the image one word per acknowledge
  // ==========================================================
  always_comb begin
    busy_next = busy_reg;
    idx_next = idx_reg;
    we_next = 1'b0;
    widx_next = widx_reg;
    wdata_next = wdata_reg;
    done_next = 1'b0;
    if (!busy_reg && start_i) begin
      busy_next = 1'b1;
      idx_next = IDX_BOARD_TYPE;
    end else if (busy_reg && nv_ack_i) begin
      we_next = 1'b1;
      widx_next = idx_reg;
      wdata_next = nv_data_i;
      if (idx_reg == IDX_LAST) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        idx_next = idx_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
      idx_reg <= IDX_BOARD_TYPE;
      we_reg <= 1'b0;
      widx_reg <= IDX_BOARD_TYPE;
      wdata_reg <= WORD_ZERO;
      done_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
      idx_reg <= idx_next;
      we_reg <= we_next;
      widx_reg <= widx_next;
      wdata_reg <= wdata_next;
      done_reg <= done_next;
    end
  end

  // Request held until the memory answers the last word
  assign nv_req_o = busy_reg;
  assign nv_addr_o = idx_reg;
  assign st_we_o = we_reg;
  assign st_idx_o = widx_reg;
  assign st_data_o = wdata_reg;
  assign done_o = done_reg;

endmodule // bib_nv_loader

/* File: verilog/bib_info_bank.sv */
// Read-only board information bank behind the parameter read port
`timescale 1ns/100ps
module bib_info_bank import bib_pkg::*; #(
  parameter int SAMPLE_BITS = 8,
  parameter bit IS_GENERATOR = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic init_done_i,
  input wire logic nv_ack_i,
  input wire logic [31:0] nv_data_i,
  input wire logic [IRQ_W-1:0] irq_line_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [NUM_W-1:0] num_i,
  output logic nv_req_o,
  output logic [IDX_W-1:0] nv_addr_o,
  output logic rd_ready_o,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  output logic rd_err_o,
  output logic wr_ignored_o,
  output logic wr_err_o,
  output logic loaded_o,
  output logic [1:0] bytes_per_sample_o,
  output logic [31:0] mem_samples_o
);

  localparam logic [1:0] BPS = (SAMPLE_BITS == NARROW_SAMPLE_BITS) ? BPS_NARROW : BPS_WIDE;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Bit IDX_W flags a hit, low bits give the slot
  function automatic logic [IDX_W:0] decode(input logic [NUM_W-1:0] n);
    logic [IDX_W:0] r;
    r = '0;
    case (n)
      NUM_BOARD_TYPE: r = {1'b1, IDX_BOARD_TYPE};
      NUM_HW_REV: r = {1'b1, IDX_HW_REV};
      NUM_EXP_REV: r = {1'b1, IDX_EXP_REV};
      NUM_DATE: r = {1'b1, IDX_DATE};
      NUM_SERIAL: r = {1'b1, IDX_SERIAL};
      NUM_MAX_RATE: r = {1'b1, IDX_MAX_RATE};
      NUM_MEM_BYTES: r = {1'b1, IDX_MEM_BYTES};
      NUM_OPTIONS: r = {1'b1, IDX_OPTIONS};
      default: r = '0;
    endcase
    return r;
  endfunction

  // Image bits that carry no meaning never reach software
  function automatic logic [31:0] sanitize(input logic [IDX_W-1:0] i, input logic [31:0] d);
    logic [31:0] r;
    r = d;
    case (i)
      IDX_HW_REV: r = d & HW_REV_MASK;
      IDX_DATE: r = d & DATE_MASK;
      IDX_OPTIONS: begin
        r = d & OPT_DEFINED;
        if (!r[OPT_SYNC_BIT]) begin
          r[OPT_HUB_BIT] = 1'b0;
        end
        if (!IS_GENERATOR) begin
          r[OPT_AMP_BIT] = 1'b0;
        end
      end
      default: r = d;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Image loader
  // ==========================================================
  logic ld_start, ld_we, ld_done;
  logic [IDX_W-1:0] ld_idx;
  logic [31:0] ld_data;

  bib_nv_loader bib_nv_loader_inst (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(ld_start),
    .nv_ack_i(nv_ack_i),
    .nv_data_i(nv_data_i),
    .nv_req_o(nv_req_o),
    .nv_addr_o(nv_addr_o),
    .st_we_o(ld_we),
    .st_idx_o(ld_idx),
    .st_data_o(ld_data),
    .done_o(ld_done)
  );

  // ==========================================================
  // Bank sequencing
  // ==========================================================
  bib_state_e state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    ld_start = 1'b0;
    case (state_reg)
      BIB_WAIT_INIT: begin
        if (init_done_i) begin
          ld_start = 1'b1;
          state_next = BIB_LOADING;
        end
      end
      BIB_LOADING: begin
        if (ld_done) begin
          state_next = BIB_READY;
        end
      end
      BIB_READY: state_next = BIB_READY;
      default: state_next = BIB_WAIT_INIT;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= BIB_WAIT_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Information store
  // ==========================================================
  // Only the loader writes here; the host port has no path in
  logic [31:0] store_reg [NV_WORDS];
  logic [31:0] store_next [NV_WORDS];
  logic [31:0] samples_reg, samples_next;

  always_comb begin
    store_next = store_reg;
    if (ld_we) begin
      store_next[ld_idx] = sanitize(ld_idx, ld_data);
    end
    samples_next = store_reg[IDX_MEM_BYTES] >> (BPS - 2'h1);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < NV_WORDS; k++) begin
        store_reg[k] <= WORD_ZERO;
      end
      samples_reg <= WORD_ZERO;
    end else begin
      store_reg <= store_next;
      samples_reg <= samples_next;
    end
  end

  // ==========================================================
  // Parameter read and write port
  // ==========================================================
  // Reads made before the image is in are held, not answered with zeros
  logic pend_reg, pend_next;
  logic [NUM_W-1:0] pnum_reg, pnum_next;
  logic valid_reg, valid_next;
  logic [31:0] data_reg, data_next;
  logic err_reg, err_next;
  logic wign_reg, wign_next;
  logic werr_reg, werr_next;
  logic [IDX_W:0] rd_hit;

  always_comb begin
    pend_next = pend_reg;
    pnum_next = pnum_reg;
    valid_next = 1'b0;
    data_next = data_reg;
    err_next = 1'b0;
    rd_hit = decode(pnum_reg);
    if (!pend_reg && rd_i) begin
      pend_next = 1'b1;
      pnum_next = num_i;
    end
    if (pend_reg && state_reg == BIB_READY) begin
      pend_next = 1'b0;
      valid_next = 1'b1;
      if (pnum_reg == NUM_IRQ_LINE) begin
        data_next = {{(32-IRQ_W){1'b0}}, irq_line_i};
      end else if (rd_hit[IDX_W]) begin
        data_next = store_reg[rd_hit[IDX_W-1:0]];
      end else begin
        data_next = WORD_ZERO;
        err_next = 1'b1;
      end
    end
    // Writes are acknowledged but never stored
    wign_next = wr_i && (decode(num_i) != '0 || num_i == NUM_IRQ_LINE);
    werr_next = wr_i && !(decode(num_i) != '0 || num_i == NUM_IRQ_LINE);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_reg <= 1'b0;
      pnum_reg <= NUM_BOARD_TYPE;
      valid_reg <= 1'b0;
      data_reg <= WORD_ZERO;
      err_reg <= 1'b0;
      wign_reg <= 1'b0;
      werr_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      pnum_reg <= pnum_next;
      valid_reg <= valid_next;
      data_reg <= data_next;
      err_reg <= err_next;
      wign_reg <= wign_next;
      werr_reg <= werr_next;
    end
  end

  assign rd_ready_o = !pend_reg;
  assign rd_valid_o = valid_reg;
  assign rd_data_o = data_reg;
  assign rd_err_o = err_reg;
  assign wr_ignored_o = wign_reg;
  assign wr_err_o = werr_reg;
  assign loaded_o = (state_reg == BIB_READY);
  assign bytes_per_sample_o = BPS;
  assign mem_samples_o = samples_reg;

  // ==========================================================
  // Checks
  // ==========================================================
  property p_wr_keeps_store;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && state_reg == BIB_READY) |=> $stable(store_reg[IDX_OPTIONS]) && $stable(store_reg[IDX_SERIAL]);
  endproperty
  a_wr_keeps_store: assert property (p_wr_keeps_store) else $error("write changed the bank");

  property p_ready_answer;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (rd_i && rd_ready_o && state_reg == BIB_READY) |=> pend_reg ##1 (rd_valid_o && !pend_reg);
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("read not answered in two cycles");

  property p_hw_rev_fields;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (pend_reg && state_reg == BIB_READY && pnum_reg == NUM_HW_REV)
      |=> rd_valid_o && rd_data_o[31:16] == 16'h0000 && rd_data_o == store_reg[IDX_HW_REV];
  endproperty
  a_hw_rev_fields: assert property (p_hw_rev_fields) else $error("hardware revision malformed");

  property p_date_fields;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (pend_reg && state_reg == BIB_READY && pnum_reg == NUM_DATE) |=> (rd_data_o & DATE_UNUSED) == WORD_ZERO;
  endproperty
  a_date_fields: assert property (p_date_fields) else $error("date unused byte set");

  property p_hub_needs_sync;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    store_reg[IDX_OPTIONS][OPT_HUB_BIT] |-> store_reg[IDX_OPTIONS][OPT_SYNC_BIT];
  endproperty
  a_hub_needs_sync: assert property (p_hub_needs_sync) else $error("star hub without sync");

  property p_amp_generator;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ld_we ##1 (!IS_GENERATOR) |-> !store_reg[IDX_OPTIONS][OPT_AMP_BIT];
  endproperty
  a_amp_generator: assert property (p_amp_generator) else $error("amplifier bit on non-generator");

  property p_opt_defined;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (pend_reg && state_reg == BIB_READY && pnum_reg == NUM_OPTIONS) |=> (rd_data_o & ~OPT_DEFINED) == WORD_ZERO;
  endproperty
  a_opt_defined: assert property (p_opt_defined) else $error("undefined option bit");

  property p_irq_line;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (pend_reg && state_reg == BIB_READY && pnum_reg == NUM_IRQ_LINE)
      |=> rd_data_o == {{(32-IRQ_W){1'b0}}, $past(irq_line_i)} && !rd_err_o;
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("interrupt line mismatch");

  property p_samples;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 mem_samples_o == ($past(store_reg[IDX_MEM_BYTES]) >> (BPS - 2'h1));
  endproperty
  a_samples: assert property (p_samples) else $error("sample count wrong");

endmodule // bib_info_bank

/* File: testbench/bib_info_bank_tb_top.sv */
// Self-checking bench for the board information bank
`timescale 1ns/100ps
module bib_info_bank_tb_top import bib_pkg::*; ;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic init_done_i = 1'b0;
  logic nv_ack_i = 1'b0;
  logic [31:0] nv_data_i = 32'h00000000;
  logic [IRQ_W-1:0] irq_line_i = '0;
  logic rd_i = 1'b0;
  logic wr_i = 1'b0;
  logic [NUM_W-1:0] num_i = '0;
  logic nv_req_o, rd_ready_o, rd_valid_o, rd_err_o, wr_ignored_o, wr_err_o, loaded_o;
  logic [IDX_W-1:0] nv_addr_o;
  logic [31:0] rd_data_o, mem_samples_o;
  logic [1:0] bytes_per_sample_o;
  logic rd_valid_g, rd_err_g, loaded_g;
  logic [31:0] rd_data_g, mem_samples_g;
  logic [1:0] bps_g;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] img [NV_WORDS];
  logic [32:0] rd_q [$];
  logic [1:0] wr_q [$];
  logic [32:0] gen_q [$];
  logic [NUM_W-1:0] nums [9] = '{NUM_BOARD_TYPE, NUM_HW_REV, NUM_EXP_REV, NUM_DATE, NUM_SERIAL,
                                 NUM_MAX_RATE, NUM_MEM_BYTES, NUM_OPTIONS, NUM_IRQ_LINE};

  bib_info_bank #(.SAMPLE_BITS(8), .IS_GENERATOR(1'b0)) bib_info_bank_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .init_done_i(init_done_i), .nv_ack_i(nv_ack_i),
    .nv_data_i(nv_data_i), .irq_line_i(irq_line_i), .rd_i(rd_i), .wr_i(wr_i), .num_i(num_i),
    .nv_req_o(nv_req_o), .nv_addr_o(nv_addr_o), .rd_ready_o(rd_ready_o), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .rd_err_o(rd_err_o), .wr_ignored_o(wr_ignored_o), .wr_err_o(wr_err_o),
    .loaded_o(loaded_o), .bytes_per_sample_o(bytes_per_sample_o), .mem_samples_o(mem_samples_o)
  );

  // Wide generator build on the same inputs; its loader walks in step with the first one
  bib_info_bank #(.SAMPLE_BITS(12), .IS_GENERATOR(1'b1)) bib_info_bank_gen_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .init_done_i(init_done_i), .nv_ack_i(nv_ack_i),
    .nv_data_i(nv_data_i), .irq_line_i(irq_line_i), .rd_i(rd_i), .wr_i(wr_i), .num_i(num_i),
    .nv_req_o(), .nv_addr_o(), .rd_ready_o(), .rd_valid_o(rd_valid_g),
    .rd_data_o(rd_data_g), .rd_err_o(rd_err_g), .wr_ignored_o(), .wr_err_o(),
    .loaded_o(loaded_g), .bytes_per_sample_o(bps_g), .mem_samples_o(mem_samples_g)
  );

  always #10 sys_clk_i = ~sys_clk_i;

  // ==========================================================
  // Expected answers
  // ==========================================================
  function automatic logic mapped(logic [NUM_W-1:0] n);
    mapped = 1'b0;
    foreach (nums[i]) begin
      if (nums[i] == n) mapped = 1'b1;
    end
  endfunction

  function automatic logic [31:0] expect_of(logic [NUM_W-1:0] n, bit gen);
    logic [31:0] o;
    o = img[IDX_OPTIONS] & OPT_DEFINED;
    if (o[OPT_SYNC_BIT] == 1'b0) o[OPT_HUB_BIT] = 1'b0;
    if (!gen) o[OPT_AMP_BIT] = 1'b0;
    case (n)
      NUM_BOARD_TYPE: expect_of = img[IDX_BOARD_TYPE];
      NUM_HW_REV: expect_of = img[IDX_HW_REV] & 32'h0000FFFF;
      NUM_EXP_REV: expect_of = img[IDX_EXP_REV];
      NUM_DATE: expect_of = img[IDX_DATE] & 32'hFFFF00FF;
      NUM_SERIAL: expect_of = img[IDX_SERIAL];
      NUM_MAX_RATE: expect_of = img[IDX_MAX_RATE];
      NUM_MEM_BYTES: expect_of = img[IDX_MEM_BYTES];
      NUM_OPTIONS: expect_of = o;
      NUM_IRQ_LINE: expect_of = {{(32-IRQ_W){1'b0}}, irq_line_i};
      default: expect_of = 32'h00000000;
    endcase
  endfunction

  task automatic check(logic [32:0] got, logic [32:0] exp, string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // Drivers
  // ==========================================================
  task automatic rd(logic [NUM_W-1:0] n);
    logic seen;
    @(posedge sys_clk_i);
    #1;
    rd_i = 1'b1;
    num_i = n;
    rd_q.push_back({~mapped(n), expect_of(n, 1'b0)});
    gen_q.push_back({~mapped(n), expect_of(n, 1'b1)});
    for (int k = 0; k < 50; k++) begin
      @(negedge sys_clk_i);
      seen = rd_ready_o;
      @(posedge sys_clk_i);
      if (seen === 1'b1) break;
    end
    #1;
    rd_i = 1'b0;
  endtask

  task automatic rd_all();
    foreach (nums[i]) rd(nums[i]);
    rd(16'h07D1);
    rd(16'h0000);
  endtask

  // Back-to-back writes, strobe held high across the whole burst
  task automatic wr_burst();
    for (int i = 0; i < 11; i++) begin
      @(posedge sys_clk_i);
      #1;
      wr_i = 1'b1;
      num_i = (i < 9) ? nums[i] : ((i == 9) ? 16'h07D1 : 16'h08FD);
      wr_q.push_back(mapped(num_i) ? 2'b10 : 2'b01);
    end
    @(posedge sys_clk_i);
    #1;
    wr_i = 1'b0;
  endtask

  // Image supplier; random stalls exercise both prompt and slow acknowledges
  always @(posedge sys_clk_i) begin
    #1;
    nv_ack_i = (nv_req_o === 1'b1) && ($urandom_range(1, 0) == 1);
    nv_data_i = nv_ack_i ? img[nv_addr_o] : ~nv_data_i;
  end

  // ==========================================================
  // Result watcher
  // ==========================================================
  always @(negedge sys_clk_i) begin
    if (rd_valid_o === 1'b1) begin
      if (rd_q.size() == 0) check(33'h1, 33'h0, "unexpected read answer");
      else check({rd_err_o, rd_data_o}, rd_q.pop_front(), "read answer");
    end
    if (rd_valid_g === 1'b1) begin
      if (gen_q.size() == 0) check(33'h1, 33'h0, "unexpected generator answer");
      else check({rd_err_g, rd_data_g}, gen_q.pop_front(), "generator read answer");
    end
    if (wr_ignored_o === 1'b1 || wr_err_o === 1'b1) begin
      if (wr_q.size() == 0) check(33'h1, 33'h0, "unexpected write answer");
      else check({31'h0, wr_ignored_o, wr_err_o}, {31'h0, wr_q.pop_front()}, "write answer");
    end
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      $display("mismatch at %0t: run too long", $time);
      close_out();
    end
  end

  // ==========================================================
  // Main sequence: two resets, hub without sync, then all options
  // ==========================================================
  initial begin
    void'($urandom(11589));
    for (int ph = 0; ph < 2; ph++) begin
      #1;
      rst_n_i = 1'b0;
      init_done_i = 1'b0;
      foreach (img[i]) img[i] = $urandom;
      if (ph == 0) img[IDX_OPTIONS] = (img[IDX_OPTIONS] | 32'h00000800) & ~32'h00000200;
      else img[IDX_OPTIONS] = img[IDX_OPTIONS] | 32'h00006E23;
      irq_line_i = IRQ_W'($urandom);
      repeat (8) @(posedge sys_clk_i);
      check({32'h0, loaded_o}, 33'h0, "loaded in reset");
      check({32'h0, rd_ready_o}, 33'h1, "ready in reset");
      #1;
      rst_n_i = 1'b1;
      rd(NUM_OPTIONS);
      @(posedge sys_clk_i);
      #1;
      init_done_i = 1'b1;
      for (int k = 0; k < 300 && loaded_o !== 1'b1; k++) @(posedge sys_clk_i);
      repeat (3) @(posedge sys_clk_i);
      check({32'h0, loaded_o}, 33'h1, "loaded");
      check({32'h0, loaded_g}, 33'h1, "generator loaded");
      check({32'h0, nv_req_o}, 33'h0, "load request after load");
      // Early read has been answered by now and its word still stands
      check({32'h0, rd_data_o[OPT_DIGITAL_BIT]}, {32'h0, img[IDX_OPTIONS][OPT_DIGITAL_BIT]}, "digital bit");
      check({31'h0, bps_g}, {31'h0, BPS_WIDE}, "wide bytes per sample");
      check({1'b0, mem_samples_g}, {1'b0, img[IDX_MEM_BYTES] >> 1}, "wide samples");
      check({31'h0, bytes_per_sample_o}, {31'h0, BPS_NARROW}, "bytes per sample");
      check({1'b0, mem_samples_o}, {1'b0, img[IDX_MEM_BYTES]}, "samples");
      rd_all();
      wr_burst();
      rd_all();
      repeat (5) @(posedge sys_clk_i);
    end
    check(33'(rd_q.size() + wr_q.size() + gen_q.size()), 33'h0, "answers missing");
    close_out();
  end
endmodule // bib_info_bank_tb_top
